// [dv/htd_hall_model.sv]
/*
  Behavioural model of the three position sensors and two capture triggers.
  Assumes the bench calls its tasks just after a rising edge of sys_clk.
*/
`timescale 1ns/1ps
module htd_hall_model (
  input wire logic sys_clk, // System clock
  output logic [2:0] hall, // Sensor levels
  output logic trig0, // Trigger line 0
  output logic trig1 // Trigger line 1
);
  // Idle levels from time zero
  initial begin
    hall = 3'h0;
    trig0 = 1'b0;
    trig1 = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One sensor edge at a time, spaced so the sync chain sees every change
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      hall <= hall ^ (3'h1 << ($urandom % 3));
      repeat (3) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask : toggle

  // Trigger pulse wide enough to pass the synchroniser
  task automatic pulse(input logic which);
    @(posedge sys_clk);
    trig0 <= ~which;
    trig1 <= which;
    repeat (3) @(posedge sys_clk);
    trig0 <= 1'b0;
    trig1 <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse
endmodule : htd_hall_model

// [dv/tb.sv]
/*
  Self-checking bench for the toggle detector and direction select.
  Assumes the register map of htd_pkg and the sensor model beside it.
*/
`timescale 1ns/1ps
module tb;
  import htd_pkg::*;
  logic sys_clk, sys_rst, run, main_dir, sub_dir, hi_mode;
  logic dir_pin, warn, flag, meth, rot, trig0, trig1;
  logic rd_seen = 1'b0;
  logic [2:0] hall;
  logic [HTD_DW-1:0] rd_data;
  logic [15:0] exp_q[$];
  htd_bus_req_t bus_req;
  int n_errors, tests_run, n_warn, cyc;

  htd_hall_model sens (.sys_clk(sys_clk), .hall(hall), .trig0(trig0), .trig1(trig1));
  htd_toggle_dir dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rd_data(rd_data), .hall_position_inputs(hall), .capture_trigger_in0(trig0),
    .capture_trigger_in1(trig1), .counter_run_enable(run), .main_dir_flag(main_dir),
    .sub_counter_direction_flag(sub_dir), .hi_acc_pwm_mode(hi_mode),
    .direction_output_pin(dir_pin), .warning_interrupt(warn),
    .abnormal_toggle_flag(flag), .output_switch_method_bit(meth), .rotation_known(rot));

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Watcher on the falling edge, where outputs have settled
  always @(negedge sys_clk) begin
    if (warn === 1'b1) n_warn++;
    if (rd_seen) chk(rd_data, exp_q.pop_front());
    rd_seen = bus_req.rd;
  end

  // Hang guard, well above the length of the sequence
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req.wr <= 1'b1;
    bus_req.addr <= a;
    // Unused upper bits carry noise, the block must ignore them
    bus_req.wdata <= d | (16'($urandom) << 3);
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read with its expectation noted for the watcher
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    bus_req.rd <= 1'b1;
    bus_req.addr <= a;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
  endtask : rd

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence; run stays low until the rotation test so STAT bit1 is 0
  initial begin
    void'($urandom(33086));
    bus_req = '0;
    {run, main_dir, sub_dir, hi_mode} = 4'h0;
    sys_rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(HTD_CTRL_OFS, 16'h0000);
    rd(HTD_STAT_OFS, 16'h0000);
    rd(HTD_METH_OFS, 16'h0000);
    wr(4'hc, 16'hffff);
    rd(4'hc, 16'h0000);
    sens.toggle(1);
    $display("test reset done");
    // Detection off while switch enabled: nothing may change
    wr(HTD_CTRL_OFS, 16'h0002);
    wr(HTD_METH_OFS, 16'h0001);
    sens.pulse(1'b0);
    sens.toggle(4);
    rd(HTD_STAT_OFS, 16'h0000);
    rd(HTD_METH_OFS, 16'h0001);
    chk(16'(n_warn), 16'h0000);
    $display("test disabled done");
    // Detect and switch: two changes are fine, the third fires once
    wr(HTD_CTRL_OFS, 16'h0006);
    rd(HTD_CTRL_OFS, 16'h0006);
    sens.pulse(1'b1);
    sens.toggle(2);
    chk(16'(n_warn), 16'h0000);
    sens.toggle(1);
    chk(16'(n_warn), 16'h0001);
    rd(HTD_STAT_OFS, 16'h0001);
    rd(HTD_METH_OFS, 16'h0000);
    // Output pins looked at away from the launching edge
    @(negedge sys_clk);
    chk(16'(flag), 16'h0001);
    chk(16'(meth), 16'h0000);
    sens.toggle(2);
    chk(16'(n_warn), 16'h0001);
    // Two changes in each of two intervals must not add up
    sens.pulse(1'b0);
    sens.toggle(2);
    sens.pulse(1'b1);
    sens.toggle(2);
    chk(16'(n_warn), 16'h0001);
    wr(HTD_STAT_OFS, 16'h0001);
    rd(HTD_STAT_OFS, 16'h0000);
    $display("test switch done");
    // Detect only: method bit keeps its 1
    wr(HTD_CTRL_OFS, 16'h0004);
    wr(HTD_METH_OFS, 16'h0001);
    sens.pulse(1'b0);
    sens.toggle(3);
    chk(16'(n_warn), 16'h0002);
    rd(HTD_STAT_OFS, 16'h0001);
    rd(HTD_METH_OFS, 16'h0001);
    @(negedge sys_clk);
    chk(16'(meth), 16'h0001);
    $display("test detect only done");
    // Rotation only known after a change seen with the counter running
    wr(HTD_STAT_OFS, 16'h0001);
    wr(HTD_CTRL_OFS, 16'h0000);
    sens.toggle(1);
    rd(HTD_STAT_OFS, 16'h0000);
    run <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(HTD_STAT_OFS, 16'h0000);
    sens.toggle(1);
    rd(HTD_STAT_OFS, 16'h0002);
    @(negedge sys_clk);
    chk(16'(rot), 16'h0001);
    $display("test rotation done");
    // Every select and mode pairing with random direction flags
    for (int i = 0; i < 8; i++) begin
      wr(HTD_CTRL_OFS, {15'h0000, i[0]});
      hi_mode <= i[1];
      main_dir <= 1'($urandom);
      sub_dir <= 1'($urandom);
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(16'(dir_pin), 16'((i[0] & i[1]) ? sub_dir : main_dir));
    end
    $display("test direction done");
    repeat (4) @(posedge sys_clk);
    complete_run();
  end
endmodule : tb

// [logic/htd_pkg.sv]
/*
  Constants, register map and carrier types of the position-sensor toggle
  detector and direction output select.
  Assumes one 50 MHz system clock and a plain register port.
*/
package htd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register port widths
  localparam int unsigned HTD_AW = 4;
  localparam int unsigned HTD_DW = 16;

  // Register byte offsets
  localparam logic [HTD_AW-1:0] HTD_CTRL_OFS = 4'h0;
  localparam logic [HTD_AW-1:0] HTD_STAT_OFS = 4'h4;
  localparam logic [HTD_AW-1:0] HTD_METH_OFS = 4'h8;

  // Control register fields
  localparam int unsigned HTD_CTRL_SEL_BIT = 0;
  localparam int unsigned HTD_CTRL_SWEN_BIT = 1;
  localparam int unsigned HTD_CTRL_DETEN_BIT = 2;

  // Status register fields
  localparam int unsigned HTD_STAT_FLAG_BIT = 0;
  localparam int unsigned HTD_STAT_ROT_BIT = 1;

  // Method register field
  localparam int unsigned HTD_METH_BIT = 0;

  // Reset values
  localparam logic HTD_METH_RST = 1'b0;
  localparam logic [HTD_DW-1:0] HTD_RD_IDLE = 16'h0000;

  // Toggle counting
  localparam logic [1:0] HTD_CNT_ZERO = 2'h0;
  localparam logic [1:0] HTD_CNT_ONE = 2'h1;
  localparam logic [1:0] HTD_CNT_LIMIT = 2'h2;
  localparam logic [1:0] HTD_CNT_SAT = 2'h3;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [HTD_AW-1:0] addr;
    logic [HTD_DW-1:0] wdata;
  } htd_bus_req_t;

  // All state of the main module
  typedef struct packed {
    logic det_en;
    logic sw_en;
    logic dir_sel;
    logic method;
    logic flag;
    logic rot_known;
    logic run_prev;
    logic [2:0] hall_prev;
    logic [1:0] trig_prev;
    logic [1:0] tog_cnt;
    logic warn;
    logic dir_out;
    logic [HTD_DW-1:0] rd_data;
  } htd_state_t;

endpackage : htd_pkg

// [logic/htd_sync.sv]
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes the inputs are asynchronous to sys_clk and change slowly
  compared with it; bits of a group may resolve one cycle apart.
*/
`timescale 1ns/1ps
module htd_sync #(
  parameter int unsigned W = 3
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);

  logic [W-1:0] meta_r;

  // A zero-width group has nothing to carry
  if (W == 0) begin : g_bad_width
    $error("htd_sync width must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : htd_sync

// [logic/htd_toggle_dir.sv]
/*
  Abnormal toggle detector for three position-sensor inputs and the
  direction output pin select.
  Assumes the counters, trigger pins and mode decode live outside; trigger
  and sensor pins are asynchronous, the rest come from sys_clk logic.
*/
`timescale 1ns/1ps
module htd_toggle_dir (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire htd_pkg::htd_bus_req_t bus_req, // Register port request
  output logic [htd_pkg::HTD_DW-1:0] rd_data, // Read data, cycle after read
  input wire logic [2:0] hall_position_inputs, // Sensor pins, async
  input wire logic capture_trigger_in0, // Trigger pin 0, async
  input wire logic capture_trigger_in1, // Trigger pin 1, async
  input wire logic counter_run_enable, // Counter running
  input wire logic main_dir_flag, // Main counter up/down flag
  input wire logic sub_counter_direction_flag, // Sub-counter up/down flag
  input wire logic hi_acc_pwm_mode, // High-accuracy PWM mode active
  output logic direction_output_pin, // Direction pin
  output logic warning_interrupt, // One-cycle warning pulse
  output logic abnormal_toggle_flag, // Sticky abnormal toggle flag
  output logic output_switch_method_bit, // Output switch method
  output logic rotation_known // Direction is determinable
);
  import htd_pkg::*;

  htd_state_t st_r;
  htd_state_t st_nxt;
  logic [2:0] hall_s;
  logic [1:0] trig_s;
  logic hall_chg;
  logic trig_ev;
  logic det_ev;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_meth;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  htd_sync #(.W(3)) u_hall_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d(hall_position_inputs),
    .q(hall_s)
  );

  htd_sync #(.W(2)) u_trig_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d({capture_trigger_in1, capture_trigger_in0}),
    .q(trig_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  assign hall_chg = hall_s != st_r.hall_prev;
  assign trig_ev = |(trig_s & ~st_r.trig_prev);
  // A change in a trigger cycle opens the new interval, so never fires
  assign det_ev = st_r.det_en && hall_chg && !trig_ev
                  && st_r.tog_cnt == HTD_CNT_LIMIT;
  assign wr_ctrl = bus_req.wr && bus_req.addr == HTD_CTRL_OFS;
  assign wr_stat = bus_req.wr && bus_req.addr == HTD_STAT_OFS;
  assign wr_meth = bus_req.wr && bus_req.addr == HTD_METH_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.hall_prev = hall_s;
    st_nxt.trig_prev = trig_s;
    st_nxt.run_prev = counter_run_enable;
    st_nxt.warn = det_ev;
    st_nxt.rd_data = HTD_RD_IDLE;

    // Software writes first, hardware events after so they win
    if (wr_ctrl) begin
      st_nxt.dir_sel = bus_req.wdata[HTD_CTRL_SEL_BIT];
      st_nxt.sw_en = bus_req.wdata[HTD_CTRL_SWEN_BIT];
      st_nxt.det_en = bus_req.wdata[HTD_CTRL_DETEN_BIT];
    end
    if (wr_stat && bus_req.wdata[HTD_STAT_FLAG_BIT]) begin
      st_nxt.flag = 1'b0;
    end
    if (wr_meth) begin
      st_nxt.method = bus_req.wdata[HTD_METH_BIT];
    end

    // Change count, saturating so one interval warns once
    if (trig_ev) begin
      st_nxt.tog_cnt = hall_chg ? HTD_CNT_ONE : HTD_CNT_ZERO;
    end else if (hall_chg && st_r.tog_cnt != HTD_CNT_SAT) begin
      st_nxt.tog_cnt = st_r.tog_cnt + HTD_CNT_ONE;
    end

    // Detection effects
    if (det_ev) begin
      st_nxt.flag = 1'b1;
      if (st_r.sw_en) begin
        st_nxt.method = 1'b0;
      end
    end

    // Rotation sense needs one change seen while running
    if (!counter_run_enable || (counter_run_enable && !st_r.run_prev)) begin
      st_nxt.rot_known = 1'b0;
    end else if (hall_chg) begin
      st_nxt.rot_known = 1'b1;
    end

    // Direction pin select, honoured only in high-accuracy PWM
    if (st_r.dir_sel && hi_acc_pwm_mode) begin
      st_nxt.dir_out = sub_counter_direction_flag;
    end else begin
      st_nxt.dir_out = main_dir_flag;
    end

    // Read port, unmapped offsets read zero
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        HTD_CTRL_OFS: begin
          st_nxt.rd_data[HTD_CTRL_SEL_BIT] = st_r.dir_sel;
          st_nxt.rd_data[HTD_CTRL_SWEN_BIT] = st_r.sw_en;
          st_nxt.rd_data[HTD_CTRL_DETEN_BIT] = st_r.det_en;
        end
        HTD_STAT_OFS: begin
          st_nxt.rd_data[HTD_STAT_FLAG_BIT] = st_r.flag;
          st_nxt.rd_data[HTD_STAT_ROT_BIT] = st_r.rot_known;
        end
        HTD_METH_OFS: begin
          st_nxt.rd_data[HTD_METH_BIT] = st_r.method;
        end
        default: begin
          st_nxt.rd_data = HTD_RD_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.method <= HTD_METH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign rd_data = st_r.rd_data;
  assign direction_output_pin = st_r.dir_out;
  assign warning_interrupt = st_r.warn;
  assign abnormal_toggle_flag = st_r.flag;
  assign output_switch_method_bit = st_r.method;
  assign rotation_known = st_r.rot_known;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_third_change;
    hall_chg && !trig_ev && st_r.tog_cnt == HTD_CNT_LIMIT;
  endsequence

  chk_off_no_flag: assert property (!st_r.det_en && !st_r.flag |=> !st_r.flag)
    else $error("flag set while detection disabled");
  chk_keep_method: assert property (st_r.det_en && !st_r.sw_en && st_r.method && !wr_meth
    |=> st_r.method)
    else $error("method bit changed with switch disabled");
  chk_clear_method: assert property (st_r.det_en && st_r.sw_en and s_third_change
    |=> !st_r.method)
    else $error("method bit not cleared on detection");
  chk_warn_third: assert property (st_r.det_en and s_third_change
    |=> warning_interrupt ##1 !warning_interrupt)
    else $error("warning not pulsed on third change");
  chk_warn_cause: assert property (warning_interrupt |-> $past(st_r.tog_cnt) == HTD_CNT_LIMIT)
    else $error("warning without three changes");
  chk_flag_with_warn: assert property (warning_interrupt |-> abnormal_toggle_flag)
    else $error("flag not set with warning");
  chk_rot_first: assert property ($rose(rotation_known)
    |-> $past(hall_chg) && $past(counter_run_enable) && $past(st_r.run_prev))
    else $error("rotation known without change while running");
  chk_dir_main: assert property (!(st_r.dir_sel && hi_acc_pwm_mode)
    |=> direction_output_pin == $past(main_dir_flag))
    else $error("direction pin not main flag");
  chk_dir_sub: assert property (st_r.dir_sel && hi_acc_pwm_mode
    |=> direction_output_pin == $past(sub_counter_direction_flag))
    else $error("direction pin not sub-counter flag");
  chk_cnt_restart: assert property (trig_ev |=> st_r.tog_cnt <= HTD_CNT_ONE)
    else $error("count not restarted at trigger");

endmodule : htd_toggle_dir
